/* rtl/hcitr_pkg.sv */
/*
  Package for the HCI UART flow-controlled transport: timing counts,
  register offsets, status bit positions, the control struct and the state types.
  Assumes a 20 MHz system clock.
*/
package hcitr_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 20000000;
  localparam int unsigned DEFAULT_BAUD   = 115200;
  localparam int unsigned MAX_BAUD       = 4000000;
  localparam logic [15:0] DIV_RESET      =
    16'((CLK_HZ + DEFAULT_BAUD / 2) / DEFAULT_BAUD);
  localparam logic [15:0] DIV_MIN        = 16'(CLK_HZ / MAX_BAUD);
  localparam logic [4:0]  IDLE_BITS      = 5'h0A;

  // ----------------------------------------------------------------------
  // Frame format
  // ----------------------------------------------------------------------
  localparam logic [3:0]  DATA_BITS      = 4'h8;

  // ----------------------------------------------------------------------
  // Receive buffer
  // ----------------------------------------------------------------------
  localparam int unsigned RXF_DEPTH      = 64;
  localparam int unsigned RXF_AW         = 6;
  localparam logic [6:0]  RXF_SLACK      = 7'h10;
  localparam logic [6:0]  RXF_THRESH     = 7'(RXF_DEPTH) - RXF_SLACK - 7'h01;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [3:0]  A_DATA         = 4'h0;
  localparam logic [3:0]  A_DIV          = 4'h1;
  localparam logic [3:0]  A_CTRL         = 4'h2;
  localparam logic [3:0]  A_STAT         = 4'h3;
  localparam logic [3:0]  A_MASK         = 4'h4;
  localparam logic [3:0]  A_LEVEL        = 4'h5;

  // ----------------------------------------------------------------------
  // Event bit positions
  // ----------------------------------------------------------------------
  localparam int unsigned EV_BREAK       = 0;
  localparam int unsigned EV_IDLE        = 1;
  localparam int unsigned EV_FRAME       = 2;
  localparam int unsigned EV_OVF         = 3;
  localparam int unsigned EV_PAR         = 4;
  localparam int unsigned EV_RXUND       = 5;
  localparam int unsigned EV_TXUND       = 6;
  localparam int unsigned EV_TXDONE      = 7;
  localparam int unsigned NEV            = 8;

  localparam logic [2:0]  CTRL_RESET     = 3'h0;

  typedef struct packed {
    logic       par_en;
    logic       par_odd;
    logic       baud_pend;
  } hcitr_ctrl_s;

  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} hcitr_tx_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} hcitr_rx_e;

endpackage

/* rtl/hcitr_uart.sv */
/*
  HCI four-wire UART transport with byte-wise hardware flow control,
  receive buffer, error detection and a deferred baud switch.
  Assumes a plain register port and asynchronous serial pins.
*/
`timescale 1ns/10ps
`default_nettype none

module hcitr_uart
  import hcitr_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  input  wire logic [3:0]  ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [15:0] RDATA,
  output logic             IRQ,
  output logic             TXD,
  input  wire logic        RXD,
  input  wire logic        HOST_TRANSMIT_PERMIT_IN,
  output logic             RTS
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [1:0] rx_sync_r;
  logic [1:0] cts_sync_r;
  logic       rxd_s;
  logic       cts_s;
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      rx_sync_r  <= 2'h3;
      cts_sync_r <= 2'h3;
    end else begin
      rx_sync_r  <= {rx_sync_r[0], RXD};
      cts_sync_r <= {cts_sync_r[0], HOST_TRANSMIT_PERMIT_IN};
    end
  end
  assign rxd_s = rx_sync_r[1];
  assign cts_s = cts_sync_r[1];

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [15:0]      div_r, div_nxt, div_pend_r, div_pend_nxt;
  hcitr_ctrl_s      ctrl_r, ctrl_nxt;
  logic [NEV-1:0]   stat_r, stat_nxt, mask_r, mask_nxt, ev;
  logic             ev_break, ev_idle, ev_frame, ev_ovf, ev_par;
  logic             ev_rxund, ev_txund, ev_txdone;
  logic [15:0]      rdata_r, rdata_nxt;
  logic [7:0]       txh_r, txh_nxt;
  logic             txh_v_r, txh_v_nxt;
  logic             tx_take, tx_done;
  logic [7:0]       rxf_q;
  logic             rxf_pop;
  logic [6:0]       rxf_cnt_r;

  always_comb begin
    div_nxt      = div_r;
    div_pend_nxt = div_pend_r;
    ctrl_nxt     = ctrl_r;
    mask_nxt     = mask_r;
    txh_nxt      = txh_r;
    txh_v_nxt    = txh_v_r && !tx_take;
    rdata_nxt    = 16'h0000;
    rxf_pop      = 1'b0;
    ev_rxund     = 1'b0;
    if (WR) begin
      unique case (ADDR)
        A_DATA: if (!txh_v_r || tx_take) begin
          txh_nxt   = WDATA[7:0];
          txh_v_nxt = 1'b1;
        end
        A_DIV: begin
          // Switch deferred until the current event bytes drain
          div_pend_nxt = (WDATA < DIV_MIN) ? DIV_MIN : WDATA;
          ctrl_nxt.baud_pend = 1'b1;
        end
        A_CTRL: begin
          ctrl_nxt.par_en  = WDATA[0];
          ctrl_nxt.par_odd = WDATA[1];
        end
        A_MASK: mask_nxt = WDATA[NEV-1:0];
        default: ;
      endcase
    end
    if (RD) begin
      unique case (ADDR)
        A_DATA: begin
          rdata_nxt = {8'h00, rxf_q};
          rxf_pop   = rxf_cnt_r != 7'h00;
          ev_rxund  = rxf_cnt_r == 7'h00;
        end
        A_DIV:   rdata_nxt = div_r;
        A_CTRL:  rdata_nxt = {13'h0000, ctrl_r.baud_pend, ctrl_r.par_odd,
                              ctrl_r.par_en};
        A_STAT:  rdata_nxt = {8'h00, stat_r};
        A_MASK:  rdata_nxt = {8'h00, mask_r};
        A_LEVEL: rdata_nxt = {txh_v_r, 8'h00, rxf_cnt_r};
        default: rdata_nxt = 16'h0000;
      endcase
    end
    // Write into a full holding register drops the byte
    ev_txund     = WR && ADDR == A_DATA && txh_v_r && !tx_take;
    // Rate moves only once the transmitter is idle and empty: event sent at old rate
    if (ctrl_r.baud_pend && tx_done && !txh_v_r) begin
      div_nxt = div_pend_r;
      ctrl_nxt.baud_pend = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------------
  hcitr_tx_e  tx_st_r, tx_st_nxt;
  logic [15:0] tx_cnt_r, tx_cnt_nxt;
  logic [3:0]  tx_bit_r, tx_bit_nxt;
  logic [8:0]  tx_sh_r, tx_sh_nxt;
  logic        txd_r, txd_nxt;
  always_comb begin
    tx_st_nxt  = tx_st_r;
    tx_cnt_nxt = tx_cnt_r - 16'h0001;
    tx_bit_nxt = tx_bit_r;
    tx_sh_nxt  = tx_sh_r;
    txd_nxt    = txd_r;
    tx_take    = 1'b0;
    tx_done    = 1'b0;
    unique case (tx_st_r)
      TX_IDLE: begin
        txd_nxt    = 1'b1;
        tx_cnt_nxt = 16'h0000;
        tx_done    = 1'b1;
        // Permit high blocks only new bytes
        if (txh_v_r && !cts_s) begin
          tx_take    = 1'b1;
          tx_sh_nxt  = {^txh_r ^ ctrl_r.par_odd, txh_r};
          tx_st_nxt  = TX_START;
          txd_nxt    = 1'b0;
          tx_cnt_nxt = div_r - 16'h0001;
          tx_done    = 1'b0;
        end
      end
      TX_START, TX_DATA: if (tx_cnt_r == 16'h0000) begin
        tx_cnt_nxt = div_r - 16'h0001;
        if (tx_st_r == TX_START) begin
          tx_bit_nxt = 4'h0;
          txd_nxt    = tx_sh_r[0];
          tx_st_nxt  = TX_DATA;
        end else if (tx_bit_r == DATA_BITS - 4'h1
                     + {3'h0, ctrl_r.par_en}) begin
          txd_nxt   = 1'b1; // Stop bit always completes
          tx_st_nxt = TX_STOP;
        end else begin
          tx_bit_nxt = tx_bit_r + 4'h1;
          txd_nxt    = tx_sh_r[tx_bit_r + 4'h1];
        end
      end
      TX_STOP: if (tx_cnt_r == 16'h0000) tx_st_nxt = TX_IDLE;
      default: ;
    endcase
  end
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      tx_st_r  <= TX_IDLE;
      tx_cnt_r <= 16'h0000;
      tx_bit_r <= 4'h0;
      tx_sh_r  <= 9'h000;
      txd_r    <= 1'b1;
    end else begin
      tx_st_r  <= tx_st_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      tx_bit_r <= tx_bit_nxt;
      tx_sh_r  <= tx_sh_nxt;
      txd_r    <= txd_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Receiver, sampling mid-bit
  // ----------------------------------------------------------------------
  hcitr_rx_e   rx_st_r, rx_st_nxt;
  logic [15:0] rx_cnt_r, rx_cnt_nxt;
  logic [3:0]  rx_bit_r, rx_bit_nxt;
  logic [8:0]  rx_sh_r, rx_sh_nxt;
  logic [15:0] idle_cnt_r, idle_cnt_nxt;
  logic [4:0]  idle_bits_r, idle_bits_nxt;
  logic        idle_arm_r, idle_arm_nxt;
  logic        rx_push;
  always_comb begin
    rx_st_nxt     = rx_st_r;
    rx_cnt_nxt    = rx_cnt_r - 16'h0001;
    rx_bit_nxt    = rx_bit_r;
    rx_sh_nxt     = rx_sh_r;
    idle_cnt_nxt  = idle_cnt_r;
    idle_bits_nxt = idle_bits_r;
    idle_arm_nxt  = idle_arm_r;
    rx_push       = 1'b0;
    ev_break      = 1'b0;
    ev_frame      = 1'b0;
    ev_par        = 1'b0;
    ev_idle       = 1'b0;
    unique case (rx_st_r)
      RX_IDLE: begin
        rx_cnt_nxt = {1'b0, div_r[15:1]};
        if (!rxd_s) rx_st_nxt = RX_START;
      end
      RX_START: if (rx_cnt_r == 16'h0000) begin
        rx_cnt_nxt = div_r - 16'h0001;
        rx_bit_nxt = 4'h0;
        // Stale parity bit would hide a break in no-parity mode
        rx_sh_nxt  = 9'h000;
        rx_st_nxt  = rxd_s ? RX_IDLE : RX_DATA;
      end
      RX_DATA: if (rx_cnt_r == 16'h0000) begin
        rx_cnt_nxt = div_r - 16'h0001;
        rx_sh_nxt[rx_bit_r] = rxd_s;
        rx_bit_nxt = rx_bit_r + 4'h1;
        if (rx_bit_r == DATA_BITS - 4'h1 + {3'h0, ctrl_r.par_en})
          rx_st_nxt = RX_STOP;
      end
      RX_STOP: if (rx_cnt_r == 16'h0000) begin
        rx_st_nxt    = RX_IDLE;
        idle_arm_nxt = 1'b1;
        if (!rxd_s && rx_sh_r == 9'h000)
          ev_break = 1'b1;
        else if (!rxd_s)
          ev_frame = 1'b1;
        else begin
          rx_push = 1'b1;
          ev_par  = ctrl_r.par_en
            && (^rx_sh_r[7:0] ^ ctrl_r.par_odd) != rx_sh_r[8];
        end
      end
      default: ;
    endcase
    // Idle after a frame: line high for a fixed number of bits
    if (rx_st_r != RX_IDLE || !rxd_s) begin
      idle_cnt_nxt  = div_r - 16'h0001;
      idle_bits_nxt = 5'h00;
    end else if (idle_arm_r) begin
      idle_cnt_nxt = idle_cnt_r - 16'h0001;
      if (idle_cnt_r == 16'h0000) begin
        idle_cnt_nxt  = div_r - 16'h0001;
        idle_bits_nxt = idle_bits_r + 5'h01;
        if (idle_bits_r == IDLE_BITS - 5'h01) begin
          ev_idle      = 1'b1;
          idle_arm_nxt = 1'b0;
        end
      end
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      rx_st_r     <= RX_IDLE;
      rx_cnt_r    <= 16'h0000;
      rx_bit_r    <= 4'h0;
      rx_sh_r     <= 9'h000;
      idle_cnt_r  <= 16'h0000;
      idle_bits_r <= 5'h00;
      idle_arm_r  <= 1'b0;
    end else begin
      rx_st_r     <= rx_st_nxt;
      rx_cnt_r    <= rx_cnt_nxt;
      rx_bit_r    <= rx_bit_nxt;
      rx_sh_r     <= rx_sh_nxt;
      idle_cnt_r  <= idle_cnt_nxt;
      idle_bits_r <= idle_bits_nxt;
      idle_arm_r  <= idle_arm_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Receive buffer and request-to-send
  // ----------------------------------------------------------------------
  // Threshold leaves sixteen bytes of slack for host latency
  logic [7:0]        rxf_mem [RXF_DEPTH];
  logic [RXF_AW-1:0] rxf_wp_r, rxf_rp_r;
  logic              rxf_wr;
  assign rxf_wr       = rx_push && rxf_cnt_r != 7'(RXF_DEPTH);
  assign ev_ovf       = rx_push && !rxf_wr;
  assign ev_txdone    = tx_st_r == TX_STOP && tx_cnt_r == 16'h0000;
  assign ev           = {ev_txdone, ev_txund, ev_rxund, ev_par, ev_ovf,
                         ev_frame, ev_idle, ev_break};
  assign rxf_q        = rxf_mem[rxf_rp_r];
  always_ff @(posedge SYS_CLK) begin
    if (rxf_wr) rxf_mem[rxf_wp_r] <= rx_sh_r[7:0];
    if (RST) begin
      rxf_wp_r  <= '0;
      rxf_rp_r  <= '0;
      rxf_cnt_r <= 7'h00;
    end else begin
      rxf_wp_r  <= rxf_wp_r + RXF_AW'(rxf_wr);
      rxf_rp_r  <= rxf_rp_r + RXF_AW'(rxf_pop);
      rxf_cnt_r <= rxf_cnt_r + 7'(rxf_wr) - 7'(rxf_pop);
    end
  end
  assign RTS = rxf_cnt_r > RXF_THRESH;

  // ----------------------------------------------------------------------
  // Status, interrupt and register state
  // ----------------------------------------------------------------------
  // Set wins over the clear-on-read
  assign stat_nxt = ((RD && ADDR == A_STAT) ? '0 : stat_r) | ev;
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      div_r      <= DIV_RESET;
      div_pend_r <= DIV_RESET;
      ctrl_r     <= CTRL_RESET;
      stat_r     <= '0;
      mask_r     <= '0;
      rdata_r    <= 16'h0000;
      txh_r      <= 8'h00;
      txh_v_r    <= 1'b0;
    end else begin
      div_r      <= div_nxt;
      div_pend_r <= div_pend_nxt;
      ctrl_r     <= ctrl_nxt;
      stat_r     <= stat_nxt;
      mask_r     <= mask_nxt;
      rdata_r    <= rdata_nxt;
      txh_r      <= txh_nxt;
      txh_v_r    <= txh_v_nxt;
    end
  end
  assign RDATA = rdata_r;
  assign IRQ   = |(stat_r & mask_r);
  assign TXD   = txd_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence permit_blocked;
    cts_s && tx_st_r == TX_IDLE;
  endsequence
  no_start_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    permit_blocked |=> tx_st_r == TX_IDLE)
    else $error("byte started while permit high");
  stop_high_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    tx_st_r == TX_STOP |-> TXD)
    else $error("stop bit not high");
  rts_level_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    RTS == (7'(RXF_DEPTH) - rxf_cnt_r <= RXF_SLACK))
    else $error("rts threshold wrong");
  baud_hold_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    tx_st_r != TX_IDLE |=> div_r == $past(div_r))
    else $error("rate changed mid byte");
  start_low_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    tx_st_r == TX_IDLE ##1 tx_st_r == TX_START |-> !TXD)
    else $error("start bit not low");
  reset_rate_a: assert property (@(posedge SYS_CLK)
    $past(RST) |-> div_r == DIV_RESET)
    else $error("reset rate wrong");
  ovf_flag_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    rx_push && rxf_cnt_r == 7'h40 |=> stat_r[EV_OVF])
    else $error("overflow not flagged");
  rx_und_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    RD && ADDR == A_DATA && rxf_cnt_r == 7'h00 |=> stat_r[EV_RXUND])
    else $error("underflow not flagged");
  irq_gate_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    RD && ADDR == A_STAT && ev == '0 |=> !IRQ)
    else $error("irq left set after status read");

endmodule

`default_nettype wire

/* verification/hcitr_host.sv */
/*
  Host model on the serial side: frame sender, frame receiver and the
  transmit permit. Assumes the bench sets div to the device's divider.
*/
`timescale 1ns/10ps
`default_nettype none
module hcitr_host
  import hcitr_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic txd,     // Three wires in all: RTS goes to the bench
  output logic      rxd,
  output logic      permit
);
  int         div  = 174;
  int         rx_n = 0;
  logic [7:0] rx_b;
  logic       rx_stop;

  initial begin
    rxd    = 1'b1;
    permit = 1'b0;
  end

  // p below zero sends no parity bit; s is the stop level
  task automatic send(input logic [7:0] d, input int p, input logic s);
    logic [11:0] f;
    f = (p < 0) ? {2'b11, s, d, 1'b0} : {1'b1, s, p[0], d, 1'b0};
    for (int b = 0; b < ((p < 0) ? 10 : 11); b++) begin
      rxd <= f[b];
      repeat (div) @(posedge sys_clk);
    end
    rxd <= 1'b1;
    @(posedge sys_clk);
  endtask

  task automatic brk(input int n);
    rxd <= 1'b0;
    repeat (n) @(posedge sys_clk);
    rxd <= 1'b1;
    @(posedge sys_clk);
  endtask

  // Pin handshake only, no flow characters
  task automatic hold(input logic on);
    permit <= on;
    @(posedge sys_clk);
    if (on) repeat (div) @(posedge sys_clk);
  endtask

  // Mid-bit sampling keeps clear of the edge race
  initial forever begin
    @(posedge sys_clk);
    if (txd === 1'b0) begin
      repeat (div / 2) @(posedge sys_clk);
      for (int b = 0; b < 8; b++) begin
        repeat (div) @(posedge sys_clk);
        rx_b[b] = txd;
      end
      repeat (div) @(posedge sys_clk);
      rx_stop = txd;
      rx_n++;
    end
  end
endmodule
`default_nettype wire

/* verification/hcitr_uart_bench.sv */
/*
  Self-checking bench for the HCI UART transport, one task a scenario.
  Assumes the host model on the serial pins and a 20 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module hcitr_uart_bench
  import hcitr_pkg::*;
;
  logic        sys_clk, rst, wr, rd, rxd, permit, irq, txd, rts;
  logic [3:0]  addr;
  logic [15:0] wdata, rdata, v;
  int          fail_count   = 0;
  int          total_checks = 0;
  int          n, k;

  hcitr_uart u_hcitr_uart (.SYS_CLK(sys_clk), .RST(rst), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq), .TXD(txd),
    .RXD(rxd), .HOST_TRANSMIT_PERMIT_IN(permit), .RTS(rts));
  hcitr_host u_hcitr_host (.sys_clk(sys_clk), .txd(txd), .rxd(rxd),
    .permit(permit));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] s);
    total_checks++;
    if (s !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, s);
      fail_count++;
    end
  endtask

  // A gap cycle after each strobe avoids re-driving it in one step
  task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rc(input string nm, input logic [3:0] a,
                    input logic [15:0] m, input logic [15:0] e);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    @(negedge sys_clk);
    v = rdata;
    @(posedge sys_clk);
    chk(nm, e, v & m);
  endtask

  task automatic waitrx(input int want);
    for (int i = 0; i < 40000 && u_hcitr_host.rx_n < want; i++)
      @(posedge sys_clk);
    if (u_hcitr_host.rx_n < want) begin
      $display("unexpected timeout waiting for host byte");
      fail_count++;
      wrap_up();
    end
  endtask

  task automatic hostb(input string nm, input logic [7:0] e);
    chk(nm, {8'h00, e}, {8'h00, u_hcitr_host.rx_b});
    chk("stop level", 16'h0001, {15'h0000, u_hcitr_host.rx_stop});
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    chk("idle line", 16'h0001, {15'h0000, txd});
    chk("rts", 16'h0000, {15'h0000, rts});
    chk("irq", 16'h0000, {15'h0000, irq});
    rc("divider", A_DIV, 16'hFFFF, DIV_RESET);
    rc("ctrl", A_CTRL, 16'hFFFF, 16'h0000);
    rc("unmapped", 4'hF, 16'hFFFF, 16'h0000);
    $display("reset test done");
  endtask

  task automatic t_tx;
    bus_wr(A_MASK, 16'h0080);
    bus_wr(A_DATA, 16'h00A5);
    waitrx(1);
    hostb("tx byte", 8'hA5);
    repeat (200) @(posedge sys_clk);
    chk("irq on", 16'h0001, {15'h0000, irq});
    rc("tx done", A_STAT, 16'h0080, 16'h0080);
    chk("irq off", 16'h0000, {15'h0000, irq});
    $display("transmit test done");
  endtask

  task automatic t_rx;
    u_hcitr_host.send(8'h3C, -1, 1'b1);
    repeat (10) @(posedge sys_clk);
    rc("level", A_LEVEL, 16'hFFFF, 16'h0001);
    rc("rx byte", A_DATA, 16'h00FF, 16'h003C);
    rc("empty read", A_DATA, 16'hFF00, 16'h0000);
    repeat (11 * 174) @(posedge sys_clk);
    rc("idle underflow", A_STAT, 16'h0022, 16'h0022);
    $display("receive test done");
  endtask

  task automatic t_permit;
    n = u_hcitr_host.rx_n;
    u_hcitr_host.hold(1'b1);
    bus_wr(A_DATA, 16'h005A);
    bus_wr(A_DATA, 16'h0011);
    rc("holding full", A_LEVEL, 16'h8000, 16'h8000);
    repeat (12 * 174) @(posedge sys_clk);
    chk("held bytes", 16'(n), 16'(u_hcitr_host.rx_n));
    u_hcitr_host.hold(1'b0);
    waitrx(n + 1);
    hostb("released byte", 8'h5A);
    rc("tx underflow", A_STAT, 16'h0040, 16'h0040);
    repeat (200) @(posedge sys_clk);
    bus_wr(A_DATA, 16'h00C3);
    repeat (3 * 174) @(posedge sys_clk);
    u_hcitr_host.hold(1'b1);
    waitrx(n + 2);
    hostb("cut byte", 8'hC3);
    bus_wr(A_DATA, 16'h0099);
    repeat (12 * 174) @(posedge sys_clk);
    chk("no new byte", 16'(n + 2), 16'(u_hcitr_host.rx_n));
    u_hcitr_host.hold(1'b0);
    waitrx(n + 3);
    hostb("late byte", 8'h99);
    $display("permit test done");
  endtask

  task automatic t_rate;
    n = u_hcitr_host.rx_n;
    bus_wr(A_DATA, 16'h000E);
    bus_wr(A_DIV, 16'h0005);
    rc("pending", A_CTRL, 16'h0004, 16'h0004);
    rc("old divider", A_DIV, 16'hFFFF, DIV_RESET);
    waitrx(n + 1);
    hostb("event at old rate", 8'h0E);
    repeat (200) @(posedge sys_clk);
    rc("new divider", A_DIV, 16'hFFFF, 16'h0005);
    rc("switched", A_CTRL, 16'h0004, 16'h0000);
    u_hcitr_host.div = 5;
    bus_wr(A_DATA, 16'h0077);
    waitrx(n + 2);
    hostb("fast byte", 8'h77);
    $display("rate test done");
  endtask

  task automatic t_fill;
    repeat (20) @(posedge sys_clk);
    rc("clear", A_STAT, 16'h0080, 16'h0080);
    n = 0;
    while (rts === 1'b0 && n < 64) begin
      u_hcitr_host.send(n[7:0], -1, 1'b1);
      repeat (4) @(posedge sys_clk);
      n++;
    end
    chk("bytes before rts", 16'h0030, 16'(n));
    while (n < 65) begin
      u_hcitr_host.send(n[7:0], -1, 1'b1);
      n++;
    end
    repeat (10) @(posedge sys_clk);
    rc("full level", A_LEVEL, 16'h007F, 16'h0040);
    rc("overflow", A_STAT, 16'h0008, 16'h0008);
    for (k = 0; k < 64; k++) rc("drain", A_DATA, 16'h00FF, 16'(k));
    chk("rts drained", 16'h0000, {15'h0000, rts});
    $display("fill test done");
  endtask

  task automatic t_err;
    bus_wr(A_MASK, 16'h0004);
    u_hcitr_host.send(8'h55, -1, 1'b0);
    repeat (10) @(posedge sys_clk);
    chk("irq framing", 16'h0001, {15'h0000, irq});
    rc("framing", A_STAT, 16'h0004, 16'h0004);
    chk("irq cleared", 16'h0000, {15'h0000, irq});
    bus_wr(A_CTRL, 16'h0001);
    u_hcitr_host.send(8'h01, 0, 1'b1);
    repeat (10) @(posedge sys_clk);
    rc("bad parity", A_STAT, 16'h0010, 16'h0010);
    u_hcitr_host.send(8'h01, 1, 1'b1);
    repeat (10) @(posedge sys_clk);
    rc("good parity", A_STAT, 16'h0010, 16'h0000);
    bus_wr(A_CTRL, 16'h0003);
    u_hcitr_host.send(8'h01, 0, 1'b1);
    repeat (10) @(posedge sys_clk);
    rc("odd parity", A_STAT, 16'h0010, 16'h0000);
    u_hcitr_host.send(8'h01, 1, 1'b1);
    repeat (10) @(posedge sys_clk);
    rc("bad odd parity", A_STAT, 16'h0010, 16'h0010);
    bus_wr(A_CTRL, 16'h0000);
    u_hcitr_host.brk(100);
    repeat (10) @(posedge sys_clk);
    rc("break", A_STAT, 16'h0001, 16'h0001);
    $display("error test done");
  endtask

  initial begin
    rst   <= 1'b1;
    wr    <= 1'b0;
    rd    <= 1'b0;
    addr  <= 4'h0;
    wdata <= 16'h0000;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_tx();
    t_rx();
    t_permit();
    t_rate();
    t_fill();
    t_err();
    wrap_up();
  end
endmodule
`default_nettype wire
